// ===== pgp_pkg.sv
package pgp_pkg;

    // ----------------------------------------
    // pin count and bus map
    // ----------------------------------------
    localparam int NPIN = 5;
    localparam logic [7:0] ARG_OFS = 8'h00; // command argument bytes
    localparam logic [7:0] CMD_OFS = 8'h04; // command code/length, write runs it
    localparam logic [7:0] RHDR_OFS = 8'h08; // reply code/length/error
    localparam logic [7:0] RDAT_OFS = 8'h0C; // reply payload bytes
    localparam logic [7:0] BOOT_OFS = 8'h10; // boot state store/load
    localparam logic [7:0] LVL_OFS = 8'h14; // sampled pin levels

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BOOT_STORE_BIT = 0;
    localparam int BOOT_LOAD_BIT = 1;
    localparam int RHDR_ERR_BIT = 16;

    // ----------------------------------------
    // command codes and limits
    // ----------------------------------------
    localparam logic [7:0] CMD_SET = 8'h22;
    localparam logic [7:0] CMD_READ = 8'h23;
    localparam logic [7:0] REPLY_BIT = 8'h40;
    localparam logic [2:0] LEN_SET_VAL = 3'h2;
    localparam logic [2:0] LEN_SET_CFG = 3'h3;
    localparam logic [2:0] LEN_READ = 3'h1;
    localparam logic [2:0] LEN_READ_RSP = 3'h4;
    localparam logic [7:0] DUTY_MAX = 8'h64; // 100 percent
    localparam logic [7:0] CFG_MAX = 8'h0F;
    localparam logic [7:0] IDX_LIMIT = 8'h05;

    // ----------------------------------------
    // drive mode encodings
    // ----------------------------------------
    localparam logic [2:0] MODE_FAST_PD = 3'h0;
    localparam logic [2:0] MODE_FAST_PP = 3'h1;
    localparam logic [2:0] MODE_HIZ = 3'h2;
    localparam logic [2:0] MODE_PU_FAST = 3'h3;
    localparam logic [2:0] MODE_SLOW_HI = 3'h4;
    localparam logic [2:0] MODE_SLOW_PP = 3'h5;
    localparam logic [2:0] MODE_SLOW_LO = 3'h7;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [3:0] RST_CFG = 4'h2; // shared function, hi-z

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int PWM_HZ = 100;
    localparam int PWM_STEPS = 100;
    localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
    localparam int SAMPLE_HZ = 32;
    localparam int SAMPLE_CYC_DEF = CLK_HZ / SAMPLE_HZ;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic fn;          // 1 = user control
        logic [2:0] mode;  // drive mode field
    } pgp_cfg_t;

    typedef struct packed {
        logic oe;
        logic out;
        logic pu;
        logic pd;
        logic slow;
    } pgp_drv_t;

endpackage

// ===== pgp_gpio_port.sv
`timescale 1ns/10ps

// Function
// R1: five pins, index 5-255 selects nothing
// R2: output high, low or 100 Hz PWM
// R3: sample all inputs at 32 Hz
// R4: latch edges per pin, clear on query
// R5: host sends 0x22 with 2 or 3 bytes
// R6: value 0 low, 1-99 duty, 100 high
// R7: config byte 0-15, F bit and mode
// R8: drive modes 000 to 011 as listed
// R9: drive modes 100, 101, 111; 110 reserved
// R10: function bit picks shared or user drive
// R11: set acknowledged with code 0x62
// R12: host reads with 0x23 and index
// R13: read reply 0x63 with four bytes
// R14: level byte bit0 level, bit1 fall, bit2 rise
// R15: report real sampled pin state
// R16: sampling free-running, short pulses may vanish
// R17: third byte is stored requested value
// R18: fourth byte config, upper bits zero
// R19: config saved and restored as boot state
// R20: bad arguments change nothing, no ack
module pgp_gpio_port
    import pgp_pkg::*;
#(
    parameter int SAMPLE_CYC = SAMPLE_CYC_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] gpio_in,
    input wire logic [4:0] dflt_out,
    input wire logic [4:0] dflt_oe,
    output logic [4:0] gpio_out,
    output logic [4:0] gpio_oe,
    output logic [4:0] gpio_pu,
    output logic [4:0] gpio_pd,
    output logic [4:0] gpio_slow
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------

    // pad drive for one pin from config and level
    function automatic pgp_drv_t pin_drive(pgp_cfg_t c, logic lvl, logic doe, logic dout);
        pgp_drv_t d;
        d = '0;
        if (!c.fn) begin
            // shared function owns the pad
            d.oe = doe; // [R10]
            d.out = dout;
        end else begin
            case (c.mode)
                MODE_FAST_PD: begin
                    d.oe = lvl; // [R8]
                    d.out = lvl;
                    d.pd = !lvl;
                end
                MODE_FAST_PP: begin
                    d.oe = 1'b1; // [R8]
                    d.out = lvl;
                end
                MODE_PU_FAST: begin
                    d.oe = !lvl; // [R8]
                    d.pu = lvl;
                end
                MODE_SLOW_HI: begin
                    d.oe = lvl; // [R9]
                    d.out = lvl;
                    d.slow = 1'b1;
                end
                MODE_SLOW_PP: begin
                    d.oe = 1'b1; // [R9]
                    d.out = lvl;
                    d.slow = 1'b1;
                end
                MODE_SLOW_LO: begin
                    d.oe = !lvl; // [R9]
                    d.slow = 1'b1;
                end
                // hi-z and reserved code: pad left floating
                default: begin
                    d.oe = 1'b0;
                end
            endcase
        end
        return d;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] duty_q [NPIN];      // requested value per pin
    pgp_cfg_t cfg_q [NPIN];         // function and mode per pin
    logic [7:0] boot_duty_q [NPIN]; // boot copy
    pgp_cfg_t boot_cfg_q [NPIN];
    logic start_q;                  // first cycle after reset
    logic [23:0] arg_q;             // index, value, config bytes
    logic [7:0] rcode_q;            // reply code, 0 when refused
    logic [2:0] rlen_q;
    logic rerr_q;
    logic [31:0] rdat_q;
    logic [4:0] lvl_q;              // last sampled levels
    logic [4:0] rise_q;
    logic [4:0] fall_q;
    logic [31:0] samp_cnt_q;
    logic [11:0] pre_cnt_q;         // pwm step prescaler
    logic [6:0] step_q;             // pwm step 0..99
    logic [4:0] out_q, oe_q, pu_q, pd_q, slow_q;

    // ----------------------------------------
    // axi4-lite slave channels
    // ----------------------------------------
    logic aw_have_q, w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    wire aw_take = s_axi_awvalid && awready_q;
    wire w_take = s_axi_wvalid && wready_q;
    wire wr_do = aw_have_q && w_have_q && !bvalid_q;
    wire aw_have_d = (aw_have_q && !wr_do) || aw_take;
    wire w_have_d = (w_have_q && !wr_do) || w_take;
    wire rd_take = s_axi_arvalid && arready_q;
    wire rvalid_d = rd_take || (rvalid_q && !s_axi_rready);

    // write address decode
    wire wa_arg = awaddr_q == ARG_OFS;
    wire wa_cmd = awaddr_q == CMD_OFS;
    wire wa_boot = awaddr_q == BOOT_OFS;
    wire wa_map = wa_arg || wa_cmd || wa_boot;

    // read address decode and data select
    wire [31:0] rsp_hdr = {15'h0000, rerr_q, 5'h00, rlen_q, rcode_q};
    wire ra_map = s_axi_araddr == ARG_OFS || s_axi_araddr == CMD_OFS
        || s_axi_araddr == RHDR_OFS || s_axi_araddr == RDAT_OFS
        || s_axi_araddr == BOOT_OFS || s_axi_araddr == LVL_OFS;
    wire [31:0] rsel =
        (s_axi_araddr == ARG_OFS) ? {8'h00, arg_q} :
        (s_axi_araddr == RHDR_OFS) ? rsp_hdr :
        (s_axi_araddr == RDAT_OFS) ? rdat_q :
        (s_axi_araddr == LVL_OFS) ? {27'h000_0000, lvl_q} : 32'h0000_0000;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    wire exec = wr_do && wa_cmd;
    wire [7:0] c_code = wdata_q[7:0];
    wire [2:0] c_len = wdata_q[10:8];
    wire [7:0] a_idx = arg_q[7:0];
    wire [7:0] a_val = arg_q[15:8];
    wire [7:0] a_cfg = arg_q[23:16];
    wire idx_ok = a_idx < IDX_LIMIT; // [R1]
    wire [2:0] pin = a_idx[2:0];
    wire set_cfg = c_len == LEN_SET_CFG;
    // value and config byte range checks
    wire set_ok = c_code == CMD_SET && (c_len == LEN_SET_VAL || set_cfg)
        && idx_ok && a_val <= DUTY_MAX && (!set_cfg || a_cfg <= CFG_MAX); // [R6] [R7] [R20]
    wire rd_ok = c_code == CMD_READ && c_len == LEN_READ && idx_ok; // [R20]

    // ----------------------------------------
    // sampling and pwm timebase
    // ----------------------------------------
    wire samp_tick = samp_cnt_q == 32'(SAMPLE_CYC - 1);
    wire step_tick = pre_cnt_q == 12'(PWM_STEP_CYC - 1);
    wire [4:0] clr = (exec && rd_ok) ? 5'(5'h01 << pin) : 5'h00;
    wire [4:0] new_rise = samp_tick ? (~lvl_q & gpio_in) : 5'h00;
    wire [4:0] new_fall = samp_tick ? (lvl_q & ~gpio_in) : 5'h00;
    wire [7:0] lvl_byte = {5'h00, rise_q[pin], fall_q[pin], lvl_q[pin]};

    // per-pin pwm level: duty 0 never high, 100 always high
    logic [4:0] pwm_lvl;
    pgp_drv_t drv [NPIN];
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            pwm_lvl[i] = {1'b0, step_q} < duty_q[i]; // [R2] [R6]
            drv[i] = pin_drive(cfg_q[i], pwm_lvl[i], dflt_oe[i], dflt_out[i]);
        end
    end

    // ----------------------------------------
    // bus handshake registers
    // ----------------------------------------

    // one write and one read in flight; address and data in any order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= !aw_have_d;
            wready_q <= !w_have_d;
            if (wr_do) begin
                bvalid_q <= 1'b1;
                bresp_q <= wa_map ? 2'h0 : 2'h2; // slverr when unmapped
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // captured write payload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) awaddr_q <= s_axi_awaddr;
            if (w_take) wdata_q <= s_axi_wdata;
            if (w_take) wstrb_q <= s_axi_wstrb;
        end
    end

    // read channel, answer one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (rd_take) begin
                rdata_q <= rsel;
                rresp_q <= ra_map ? 2'h0 : 2'h2;
            end
        end
    end

    // ----------------------------------------
    // argument and reply registers
    // ----------------------------------------

    // argument honours byte strobes; reply header updated by every command, payload only by accepted reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arg_q <= 24'h00_0000;
            rcode_q <= 8'h00;
            rlen_q <= 3'h0;
            rerr_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            if (wr_do && wa_arg) begin
                for (int b = 0; b < 3; b++) begin
                    if (wstrb_q[b]) arg_q[8*b +: 8] <= wdata_q[8*b +: 8];
                end
            end
            if (exec) begin
                rerr_q <= !(set_ok || rd_ok); // [R20]
                rcode_q <= (set_ok || rd_ok) ? (c_code | REPLY_BIT) : 8'h00; // [R11] [R13]
                rlen_q <= rd_ok ? LEN_READ_RSP : 3'h0;
                if (rd_ok) begin
                    // index, level/edges, stored value, config
                    rdat_q <= {4'h0, cfg_q[pin], duty_q[pin], lvl_byte, a_idx}; // [R13] [R14] [R17] [R18]
                end
            end
        end
    end

    // ----------------------------------------
    // pin configuration and boot copy
    // ----------------------------------------

    // boot copy holds factory defaults until software stores
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 1'b1;
            for (int i = 0; i < NPIN; i++) begin
                duty_q[i] <= RST_DUTY;
                cfg_q[i] <= RST_CFG;
                boot_duty_q[i] <= RST_DUTY;
                boot_cfg_q[i] <= RST_CFG;
            end
        end else begin
            start_q <= 1'b0;
            if (start_q || (wr_do && wa_boot && wdata_q[BOOT_LOAD_BIT])) begin
                // startup or load-bit restore from boot copy
                for (int i = 0; i < NPIN; i++) begin
                    duty_q[i] <= boot_duty_q[i]; // [R19]
                    cfg_q[i] <= boot_cfg_q[i];
                end
            end else if (exec && set_ok) begin
                duty_q[pin] <= a_val; // [R5]
                if (set_cfg) cfg_q[pin] <= a_cfg[3:0]; // [R7]
            end
            if (wr_do && wa_boot && wdata_q[BOOT_STORE_BIT]) begin
                for (int i = 0; i < NPIN; i++) begin
                    boot_duty_q[i] <= duty_q[i]; // [R19]
                    boot_cfg_q[i] <= cfg_q[i];
                end
            end
        end
    end

    // ----------------------------------------
    // input sampling and edge latches
    // ----------------------------------------

    // free-running; a pulse between two ticks is missed by design
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samp_cnt_q <= 32'h0000_0000;
            lvl_q <= 5'h00;
            rise_q <= 5'h00;
            fall_q <= 5'h00;
        end else begin
            samp_cnt_q <= samp_tick ? 32'h0000_0000 : samp_cnt_q + 32'h0000_0001; // [R16]
            if (samp_tick) lvl_q <= gpio_in; // [R3] [R15]
            // a new edge in the clearing cycle wins over the clear
            rise_q <= (rise_q & ~clr) | new_rise; // [R4]
            fall_q <= (fall_q & ~clr) | new_fall; // [R4]
        end
    end

    // ----------------------------------------
    // pwm and pad outputs
    // ----------------------------------------

    // 100 steps of one percent each make one 100 Hz period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_q <= 12'h000;
            step_q <= 7'h00;
        end else begin
            pre_cnt_q <= step_tick ? 12'h000 : pre_cnt_q + 12'h001;
            if (step_tick) begin
                step_q <= (step_q == 7'(PWM_STEPS - 1)) ? 7'h00 : step_q + 7'h01; // [R2]
            end
        end
    end

    // registered pad controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_q <= 5'h00;
            oe_q <= 5'h00;
            pu_q <= 5'h00;
            pd_q <= 5'h00;
            slow_q <= 5'h00;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                out_q[i] <= drv[i].out;
                oe_q[i] <= drv[i].oe; // [R10]
                pu_q[i] <= drv[i].pu;
                pd_q[i] <= drv[i].pd;
                slow_q[i] <= drv[i].slow;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign gpio_out = out_q;
    assign gpio_oe = oe_q;
    assign gpio_pu = pu_q;
    assign gpio_pd = pd_q;
    assign gpio_slow = slow_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // pin 4 is the one the bench walks through drive modes 000, 001, 010, 011 and 101
    wire hiz4 = cfg_q[4] == {1'b1, MODE_HIZ};

    a_reserved_index: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
        exec && !idx_ok |=> rcode_q == 8'h00 && rerr_q)
        else $error("reserved index acknowledged");
    a_set_ack_code: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        exec && set_ok |=> rcode_q == 8'h62 && rlen_q == 3'h0)
        else $error("set reply wrong");
    a_read_ack_code: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
        exec && rd_ok |=> rcode_q == 8'h63 && rlen_q == 3'h4 && rdat_q[7:0] == $past(a_idx))
        else $error("read reply wrong");
    a_sample_level: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
        samp_tick |=> lvl_q == $past(gpio_in))
        else $error("sample not taken");
    a_rise_latch: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        samp_tick && !lvl_q[4] && gpio_in[4] |=> rise_q[4] ##1 (rise_q[4] || $past(clr[4])))
        else $error("rising edge lost");
    a_cfg_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
        rcode_q == 8'h63 |-> rdat_q[31:28] == 4'h0 && rdat_q[15:11] == 5'h00)
        else $error("reserved reply bits set");
    a_bad_value_kept: assert property (@(posedge aclk) disable iff (!aresetn || start_q) // [R20]
        exec && c_code == CMD_SET && a_val > DUTY_MAX |=> $stable(duty_q[4]) && $stable(cfg_q[4]))
        else $error("invalid value applied");
    a_hiz_no_drive: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
        hiz4 && $past(hiz4) |-> !gpio_oe[4] && !gpio_pu[4] && !gpio_pd[4])
        else $error("hi-z pin driven");
    a_duty_zero_low: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
        duty_q[0] == 8'h00 |-> !pwm_lvl[0])
        else $error("zero duty went high");

endmodule

// ===== pgp_pin_load.sv
`timescale 1ns/10ps

// ----------------------------------------
// pad-side load: resolves pin levels
// ----------------------------------------
module pgp_pin_load (
    input wire logic [4:0] gpio_out,
    input wire logic [4:0] gpio_oe,
    input wire logic [4:0] gpio_pu,
    input wire logic [4:0] gpio_pd,
    input wire logic [4:0] ext_en,
    input wire logic [4:0] ext_lvl,
    output logic [4:0] gpio_in
);
    // strong drive wins, then a stiff outside load, then the weak pulls
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (gpio_oe[i]) begin
                gpio_in[i] = gpio_out[i];
            end else if (ext_en[i] || !(gpio_pu[i] || gpio_pd[i])) begin
                gpio_in[i] = ext_lvl[i]; // outside load beats a 5k pull
            end else begin
                gpio_in[i] = gpio_pu[i];
            end
        end
    end
endmodule

// ===== packet_gpio_port_pwm_tb.sv
`timescale 1ns/10ps

module packet_gpio_port_pwm_tb;
    import pgp_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, h, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [4:0] gpio_in, dflt_out, dflt_oe, gpio_out, gpio_oe, gpio_pu, gpio_pd, gpio_slow;
    logic [4:0] ext_en, ext_lvl;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    // bad requests: code, length, {config, value, index}
    logic [34:0] bad [6] = '{{8'h22, 3'h3, 24'h00_0005}, {8'h22, 3'h3, 24'h09_6504},
        {8'h22, 3'h3, 24'h10_0004}, {8'h24, 3'h1, 24'h00_0004},
        {8'h23, 3'h2, 24'h00_0004}, {8'h23, 3'h1, 24'h00_0005}};

    // short sample period keeps edge tests quick
    pgp_gpio_port #(.SAMPLE_CYC(16)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .gpio_in(gpio_in),
        .dflt_out(dflt_out), .dflt_oe(dflt_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_pu(gpio_pu), .gpio_pd(gpio_pd), .gpio_slow(gpio_slow));

    pgp_pin_load load (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pu(gpio_pu),
        .gpio_pd(gpio_pd), .ext_en(ext_en), .ext_lvl(ext_lvl), .gpio_in(gpio_in));

    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // whole run needs well under 3000 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ready sampled before the edge, so the registered answer never races us
    task automatic axw(input logic [7:0] a, input logic [31:0] dw, output logic [1:0] rs);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= dw;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk); // idle edge: the next call may raise bready again
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rs);
        logic ta, tv;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tv = 1'b0;
        while (!tv) begin
            @(negedge aclk);
            ta = s_axi_arready;
            tv = s_axi_rvalid;
            dr = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk); // idle edge: the next call may raise rready again
    endtask

    // one packet: argument word, then code word, then both reply words
    task automatic cmd(input logic [7:0] c, input logic [2:0] n, input logic [23:0] arg);
        axw(ARG_OFS, {8'h00, arg}, r);
        axw(CMD_OFS, {21'h0, n, c}, r);
        axr(RHDR_OFS, h, r);
        axr(RDAT_OFS, d, r);
    endtask

    task automatic rdpin(input logic [7:0] idx, input logic [31:0] exp);
        cmd(CMD_READ, LEN_READ, {16'h0000, idx});
        chk(h, 32'h0000_0463);
        chk(d, exp);
    endtask

    // pin 4 pad controls in order oe, out, pu, pd, slow
    task automatic pad(input logic [4:0] e, input logic [4:0] m);
        chk({27'h0, {gpio_oe[4], gpio_out[4], gpio_pu[4], gpio_pd[4], gpio_slow[4]} & m},
            {27'h0, e});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_set;
        rdpin(8'h00, 32'h0200_0000);
        cmd(CMD_SET, LEN_SET_CFG, 24'h09_6404);
        chk(h, 32'h0000_0062);
        pad(5'b11000, 5'b11001);
        repeat (40) @(posedge aclk);
        rdpin(8'h04, 32'h0964_0504);
        rdpin(8'h04, 32'h0964_0104);
        cmd(CMD_SET, LEN_SET_VAL, 24'h00_0004); // config byte must be ignored here
        chk(h, 32'h0000_0062);
        repeat (40) @(posedge aclk);
        rdpin(8'h04, 32'h0900_0204);
    endtask

    task automatic t_refuse;
        foreach (bad[i]) begin
            cmd(bad[i][34:27], bad[i][26:24], bad[i][23:0]);
            chk(h & 32'h0001_00FF, 32'h0001_0000);
        end
        rdpin(8'h04, 32'h0900_0004);
    endtask

    task automatic t_modes;
        ext_en[4] <= 1'b1;
        cmd(CMD_SET, LEN_SET_CFG, 24'h0B_6404);
        pad(5'b00100, 5'b10110);
        repeat (40) @(posedge aclk);
        rdpin(8'h04, 32'h0B64_0004);
        ext_en[4] <= 1'b0;
        repeat (40) @(posedge aclk);
        rdpin(8'h04, 32'h0B64_0504);
        cmd(CMD_SET, LEN_SET_CFG, 24'h08_0004);
        pad(5'b00010, 5'b10110);
        cmd(CMD_SET, LEN_SET_CFG, 24'h0A_6404);
        pad(5'b00000, 5'b10110);
        cmd(CMD_SET, LEN_SET_CFG, 24'h0D_0004);
        pad(5'b10001, 5'b11001);
        dflt_oe[4] <= 1'b1;
        cmd(CMD_SET, LEN_SET_CFG, 24'h01_6404);
        pad(5'b10000, 5'b11000);
    endtask

    task automatic t_boot;
        axw(BOOT_OFS, 32'h0000_0001, r);
        chk({30'h0, r}, 32'h0000_0000);
        cmd(CMD_SET, LEN_SET_CFG, 24'h0D_0004);
        axw(BOOT_OFS, 32'h0000_0002, r);
        repeat (40) @(posedge aclk);
        rdpin(8'h04, 32'h0164_0204);
        axw(8'h18, 32'h0000_0001, r); // unmapped write
        chk({30'h0, r}, 32'h0000_0002);
        axr(8'h18, d, r);
        chk({r, d[29:0]}, 32'h8000_0000);
    endtask

    task automatic print_verdict;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        {dflt_out, dflt_oe, ext_en, ext_lvl} = 20'h0_0000;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_set();
        t_refuse();
        t_modes();
        t_boot();
        print_verdict();
    end
endmodule
